// *** hdl/framer_sig_pkg.sv ***
// Constants for the framer signaling capture and common control register bank.
// Assumes a 25 MHz register clock and word-aligned register indices on the bus.
package framer_sig_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] RX_SIG_FIRST_IDX = 8'h60;
  localparam logic [7:0] RX_SIG_T1_LAST_IDX = 8'h6B;
  localparam logic [7:0] RX_SIG_LAST_IDX = 8'h6F;
  localparam logic [7:0] COMMON_CTRL_1_IDX = 8'h70;
  localparam logic [7:0] COMMON_CTRL_2_IDX = 8'h71;
  localparam logic [7:0] COMMON_CTRL_3_IDX = 8'h72;
  localparam logic [7:0] PORT_STATUS_IDX = 8'h7F;
  // Common control 1 fields
  localparam int MASTER_CLOCK_SOURCE_SEL_BIT = 7;
  localparam int CHECKSUM_RECALC_MODE_BIT = 6;
  localparam int SIGNALING_INTEGRATION_EN_BIT = 5;
  localparam int OUTPUT_PULSE_WIDTH_SEL_BIT = 4;
  localparam int IDLE_ADDR_AUTOINC_DISABLE_BIT = 3;
  localparam int TX_CLOCK_SOURCE_SEL_HI_BIT = 2;
  localparam int TX_CLOCK_SOURCE_SEL_LO_BIT = 1;
  localparam int LOSS_OUTPUT_FUNCTION_SEL_BIT = 0;
  // Common control 2 fields
  localparam int BACKPLANE_FREQ_SEL_HI_BIT = 2;
  localparam int BACKPLANE_FREQ_SEL_LO_BIT = 1;
  localparam int BACKPLANE_CLOCK_ENABLE_BIT = 0;
  // Common control 3 fields
  localparam int TX_MULTIFRAME_SYNC_SOURCE_BIT = 7;
  localparam int GLOBAL_INTERRUPT_DISABLE_BIT = 6;
  localparam int TX_CHANNEL_RATE_SEL_BIT = 3;
  localparam int TX_GAPPED_CLOCK_EN_BIT = 2;
  localparam int RX_CHANNEL_RATE_SEL_BIT = 1;
  localparam int RX_GAPPED_CLOCK_EN_BIT = 0;
  // Reset values
  localparam logic [7:0] COMMON_CTRL_1_RESET = 8'h00;
  localparam logic [7:0] COMMON_CTRL_2_RESET = 8'h00;
  localparam logic [7:0] COMMON_CTRL_3_RESET = 8'h00;
  localparam logic [7:0] RX_SIG_RESET = 8'h00;
  // Transmit clock source codes
  localparam logic [1:0] TX_CLK_INPUT_ONLY = 2'h0;
  localparam logic [1:0] TX_CLK_FALLBACK = 2'h1;
  localparam logic [1:0] TX_CLK_SCALED_MASTER = 2'h2;
  localparam logic [1:0] TX_CLK_RECOVERED = 2'h3;
  // Timing: one channel time, and the multiframes a new value must hold
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int CHANNEL_TIME_NS = 3900;
  localparam int CHANNEL_TIME_CYCLES = (CHANNEL_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [1:0] INTEGRATION_MULTIFRAMES = 2'h3;
  localparam int CCS_BITS = 128;
  typedef enum logic [1:0] {MODE_T1_ESF, MODE_T1_D4, MODE_E1_CAS, MODE_E1_CCS} frame_mode_type;
endpackage

// *** hdl/framer_signaling_common_ctrl.sv ***
// Register bank of one framer port: receive signaling capture and common controls 1 to 3.
// Assumes framer-side strobes share mclk_i; clock pins from the line are sampled here.
// Contract
// RULE1: ESF: even channel high nibble, odd low
// RULE2: D4: each nibble holds A,B,A,B of channel
// RULE3: CAS: zeros over spare bits, then channels
// RULE4: CCS: 128 bits, earliest at first MSB
// RULE5: Master clock from pin or system clock
// RULE6: Checksum recalculation mode select
// RULE7: Integration needs three stable multiframes
// RULE8: Pulse width full or half clock
// RULE9: Idle address advances unless disabled
// RULE10: Modes 00/01: input clock, fallback on loss
// RULE11: Modes 10/11: scaled master or recovered clock
// RULE12: Loss output shows sync or clock loss
// RULE13: Backplane frequency from two select bits
// RULE14: Backplane clock low when disabled
// RULE15: Backplane active only in ports 1, 2
// RULE16: Control 3 fields, reset to zero
// RULE17: Interrupt disable overrides all masks
// RULE18: Multiframe sync source select
// RULE19: Channel rate 64k or 56k each direction
// RULE20: Signaling read-only, updated each multiframe
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
module framer_signaling_common_ctrl #(
  parameter int PORT_NUM = 1,
  parameter int TX_SCALE_HALF = 6
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Framer signaling capture
  input wire logic [1:0] frame_mode_i,
  input wire logic ch_sig_valid_i,
  input wire logic [4:0] ch_num_i,
  input wire logic [3:0] ch_abcd_i,
  input wire logic [3:0] spare_bits_i,
  input wire logic ccs_bit_valid_i,
  input wire logic ccs_bit_i,
  input wire logic multiframe_end_i,
  output logic sig_change_o,
  // Line clocks and transmit data
  input wire logic tx_clock_input_i,
  input wire logic rx_recovered_clock_i,
  input wire logic tx_pos_bit_i,
  input wire logic tx_neg_bit_i,
  output logic tx_output_clock_o,
  output logic tx_positive_data_out_o,
  output logic tx_negative_data_out_o,
  // Loss indication and interrupts
  input wire logic rx_sync_loss_i,
  output logic loss_indication_o,
  input wire logic int_req_i,
  output logic irq_o,
  // Idle code array
  input wire logic idle_code_access_i,
  output logic idle_addr_advance_o,
  // Backplane clock
  input wire logic bp_tick_i,
  output logic backplane_clock_out_o,
  // Static controls
  output logic master_clock_source_sel_o,
  output logic checksum_recalc_mode_o,
  output logic tx_multiframe_sync_source_o,
  output logic tx_channel_rate_sel_o,
  output logic tx_gapped_clock_en_o,
  output logic rx_channel_rate_sel_o,
  output logic rx_gapped_clock_en_o
);
  initial begin
    if (PORT_NUM < 1 || PORT_NUM > 4) $error("PORT_NUM must be 1 to 4");
    if (TX_SCALE_HALF < 1 || TX_SCALE_HALF > 255) $error("TX_SCALE_HALF must be 1 to 255");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] ccr1;
    logic [7:0] ccr2;
    logic [7:0] ccr3;
    logic [15:0][7:0] vis;
    logic [15:0][7:0] shadow;
    logic [31:0][3:0] cand;
    logic [31:0][1:0] cnt;
    logic [6:0] ccs_cnt;
    logic sig_chg;
    logic tck_s1;
    logic tck_s2;
    logic tck_d;
    logic rck_s1;
    logic rck_s2;
    logic [7:0] idle_cnt;
    logic tx_loss;
    logic [7:0] scale_cnt;
    logic scale_clk;
    logic tclk;
    logic tpos;
    logic tneg;
    logic loss_out;
    logic [3:0] bp_cnt;
    logic bp;
    logic irq;
    logic idle_adv;
  } state_type;

  state_type st_r;
  state_type st_nxt;
  logic req;
  logic [7:0] idx;
  logic tx_sel_clk;
  framer_sig_pkg::frame_mode_type mode;

  // Byte holding a channel nibble: CAS starts one byte later to leave room for spares
  function automatic logic [3:0] chan_byte(input logic [4:0] ch, input logic cas);
    logic [4:0] b;
    b = (ch - 5'd1) >> 1;
    chan_byte = b[3:0] + {3'h0, cas};
  endfunction

  assign mode = framer_sig_pkg::frame_mode_type'(frame_mode_i);
  assign req = avs_read_i | avs_write_i;
  assign idx = avs_address_i[9:2];
  assign avs_waitrequest_o = req & ~st_r.ack;
  assign avs_readdata_o = st_r.rdata;

  always_comb begin
    unique case (st_r.ccr1[2:1])
      framer_sig_pkg::TX_CLK_INPUT_ONLY: tx_sel_clk = st_r.tck_s2; // RULE10
      framer_sig_pkg::TX_CLK_FALLBACK: begin
        tx_sel_clk = st_r.tx_loss ? st_r.rck_s2 : st_r.tck_s2; // RULE10
      end
      framer_sig_pkg::TX_CLK_SCALED_MASTER: tx_sel_clk = st_r.scale_clk; // RULE11
      framer_sig_pkg::TX_CLK_RECOVERED: tx_sel_clk = st_r.rck_s2; // RULE11
    endcase
  end

  always_comb begin
    logic cas;
    logic ccs;
    logic signaling_integration_en;
    logic [3:0] b;
    logic [3:0] nw;
    logic [3:0] old;
    logic chg;
    cas = (mode == framer_sig_pkg::MODE_E1_CAS);
    ccs = (mode == framer_sig_pkg::MODE_E1_CCS);
    signaling_integration_en = st_r.ccr1[framer_sig_pkg::SIGNALING_INTEGRATION_EN_BIT];
    b = 4'h0;
    nw = 4'h0;
    old = 4'h0;
    chg = 1'b0;
    st_nxt = st_r;

    // Bus: capture read data at the first edge, apply a write at the accepting edge
    if (st_r.ack) begin
      st_nxt.ack = 1'b0;
      if (avs_write_i && avs_byteenable_i[0]) begin
        unique case (idx)
          framer_sig_pkg::COMMON_CTRL_1_IDX: st_nxt.ccr1 = avs_writedata_i[7:0];
          framer_sig_pkg::COMMON_CTRL_2_IDX: st_nxt.ccr2 = {5'h00, avs_writedata_i[2:0]};
          framer_sig_pkg::COMMON_CTRL_3_IDX: st_nxt.ccr3 = {avs_writedata_i[7:6], 2'h0,
                                                            avs_writedata_i[3:0]}; // RULE16
          default: st_nxt.ack = 1'b0; // RULE20
        endcase
      end
    end else if (req) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      if (idx >= framer_sig_pkg::RX_SIG_FIRST_IDX && idx <= framer_sig_pkg::RX_SIG_LAST_IDX) begin
        st_nxt.rdata[7:0] = st_r.vis[idx[3:0]];
      end else if (idx == framer_sig_pkg::COMMON_CTRL_1_IDX) begin
        st_nxt.rdata[7:0] = st_r.ccr1;
      end else if (idx == framer_sig_pkg::COMMON_CTRL_2_IDX) begin
        st_nxt.rdata[7:0] = st_r.ccr2;
      end else if (idx == framer_sig_pkg::COMMON_CTRL_3_IDX) begin
        st_nxt.rdata[7:0] = st_r.ccr3;
      end else if (idx == framer_sig_pkg::PORT_STATUS_IDX) begin
        st_nxt.rdata[3:0] = {tx_sel_clk == st_r.rck_s2, rx_sync_loss_i, st_r.tx_loss,
                             st_r.sig_chg};
      end
    end

    // Capture of signaling into the shadow during the multiframe
    if (ch_sig_valid_i && !ccs && ch_num_i != 5'd0 &&
        ch_num_i <= (cas ? 5'd30 : 5'd24)) begin
      b = chan_byte(ch_num_i, cas);
      if (ch_num_i[0]) begin
        st_nxt.shadow[b][3:0] = ch_abcd_i; // RULE1 RULE2 RULE3
      end else begin
        st_nxt.shadow[b][7:4] = ch_abcd_i; // RULE1 RULE2 RULE3
      end
    end
    if (cas) begin
      st_nxt.shadow[0] = {4'h0, spare_bits_i}; // RULE3
    end
    if (ccs_bit_valid_i && ccs) begin
      st_nxt.shadow[st_r.ccs_cnt[6:3]][3'd7 - st_r.ccs_cnt[2:0]] = ccs_bit_i; // RULE4
      st_nxt.ccs_cnt = st_r.ccs_cnt + 7'd1;
    end

    // Multiframe boundary: publish, with optional three-multiframe integration
    st_nxt.sig_chg = 1'b0;
    if (multiframe_end_i) begin
      st_nxt.ccs_cnt = 7'd0;
      for (int p = 0; p < 32; p++) begin
        nw = st_r.shadow[p / 2][(p % 2) * 4 +: 4];
        old = st_r.vis[p / 2][(p % 2) * 4 +: 4];
        if (ccs || (cas && p < 2) || (p >= 24 && !cas)) begin
          st_nxt.vis[p / 2][(p % 2) * 4 +: 4] = (p >= 24 && !cas && !ccs) ? 4'h0 : nw; // RULE20
        end else if (nw == old) begin
          st_nxt.cnt[p] = 2'h0;
        end else if (!signaling_integration_en) begin
          st_nxt.vis[p / 2][(p % 2) * 4 +: 4] = nw; // RULE7
          chg = 1'b1;
        end else if (nw != st_r.cand[p]) begin
          st_nxt.cand[p] = nw;
          st_nxt.cnt[p] = 2'h1;
        end else if (st_r.cnt[p] + 2'h1 == framer_sig_pkg::INTEGRATION_MULTIFRAMES) begin
          st_nxt.vis[p / 2][(p % 2) * 4 +: 4] = nw; // RULE7
          st_nxt.cnt[p] = 2'h0;
          chg = 1'b1;
        end else begin
          st_nxt.cnt[p] = st_r.cnt[p] + 2'h1;
        end
      end
      st_nxt.sig_chg = chg;
    end

    // Line clock sampling and loss of transmit clock after one channel time
    st_nxt.tck_s1 = tx_clock_input_i;
    st_nxt.tck_s2 = st_r.tck_s1;
    st_nxt.tck_d = st_r.tck_s2;
    st_nxt.rck_s1 = rx_recovered_clock_i;
    st_nxt.rck_s2 = st_r.rck_s1;
    if (st_r.tck_s2 != st_r.tck_d) begin
      st_nxt.idle_cnt = 8'h00;
      st_nxt.tx_loss = 1'b0;
    end else if (st_r.idle_cnt == 8'(framer_sig_pkg::CHANNEL_TIME_CYCLES - 1)) begin
      st_nxt.tx_loss = 1'b1; // RULE10
    end else begin
      st_nxt.idle_cnt = st_r.idle_cnt + 8'h01;
    end

    // Scaled master clock
    if (st_r.scale_cnt == 8'(TX_SCALE_HALF - 1)) begin
      st_nxt.scale_cnt = 8'h00;
      st_nxt.scale_clk = ~st_r.scale_clk; // RULE11
    end else begin
      st_nxt.scale_cnt = st_r.scale_cnt + 8'h01;
    end

    // Transmit outputs; half width keeps data only while the selected clock is high
    st_nxt.tclk = tx_sel_clk;
    st_nxt.tpos = tx_pos_bit_i & (~st_r.ccr1[framer_sig_pkg::OUTPUT_PULSE_WIDTH_SEL_BIT] |
                                  tx_sel_clk); // RULE8
    st_nxt.tneg = tx_neg_bit_i & (~st_r.ccr1[framer_sig_pkg::OUTPUT_PULSE_WIDTH_SEL_BIT] |
                                  tx_sel_clk); // RULE8
    st_nxt.loss_out = st_r.ccr1[framer_sig_pkg::LOSS_OUTPUT_FUNCTION_SEL_BIT] ?
                      st_r.tx_loss : rx_sync_loss_i; // RULE12

    // Backplane clock: counter bit k is the tick rate halved k+1 times
    if (bp_tick_i) begin
      st_nxt.bp_cnt = st_r.bp_cnt + 4'h1; // RULE13
    end
    st_nxt.bp = (PORT_NUM <= 2) && st_r.ccr2[framer_sig_pkg::BACKPLANE_CLOCK_ENABLE_BIT] &&
                st_r.bp_cnt[st_r.ccr2[2:1]]; // RULE13 RULE14 RULE15

    st_nxt.irq = int_req_i &
                 ~st_r.ccr3[framer_sig_pkg::GLOBAL_INTERRUPT_DISABLE_BIT]; // RULE17
    st_nxt.idle_adv = idle_code_access_i &
                      ~st_r.ccr1[framer_sig_pkg::IDLE_ADDR_AUTOINC_DISABLE_BIT]; // RULE9
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.ccr1 <= framer_sig_pkg::COMMON_CTRL_1_RESET;
      st_r.ccr2 <= framer_sig_pkg::COMMON_CTRL_2_RESET;
      st_r.ccr3 <= framer_sig_pkg::COMMON_CTRL_3_RESET; // RULE16
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sig_change_o = st_r.sig_chg;
  assign tx_output_clock_o = st_r.tclk;
  assign tx_positive_data_out_o = st_r.tpos;
  assign tx_negative_data_out_o = st_r.tneg;
  assign loss_indication_o = st_r.loss_out;
  assign irq_o = st_r.irq;
  assign idle_addr_advance_o = st_r.idle_adv;
  assign backplane_clock_out_o = st_r.bp;
  assign master_clock_source_sel_o =
    st_r.ccr1[framer_sig_pkg::MASTER_CLOCK_SOURCE_SEL_BIT]; // RULE5
  assign checksum_recalc_mode_o = st_r.ccr1[framer_sig_pkg::CHECKSUM_RECALC_MODE_BIT]; // RULE6
  assign tx_multiframe_sync_source_o =
    st_r.ccr3[framer_sig_pkg::TX_MULTIFRAME_SYNC_SOURCE_BIT]; // RULE18
  assign tx_channel_rate_sel_o = st_r.ccr3[framer_sig_pkg::TX_CHANNEL_RATE_SEL_BIT]; // RULE19
  assign tx_gapped_clock_en_o = st_r.ccr3[framer_sig_pkg::TX_GAPPED_CLOCK_EN_BIT]; // RULE16
  assign rx_channel_rate_sel_o = st_r.ccr3[framer_sig_pkg::RX_CHANNEL_RATE_SEL_BIT]; // RULE19
  assign rx_gapped_clock_en_o = st_r.ccr3[framer_sig_pkg::RX_GAPPED_CLOCK_EN_BIT]; // RULE16

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_irq_disable_gate: assert property (st_r.ccr3[6] |=> !irq_o) // RULE17
    else $error("interrupt raised while globally disabled");
  a_loss_output_mux: assert property (st_r.ccr1[0] && st_r.tx_loss |=> loss_indication_o) // RULE12
    else $error("loss output does not show transmit clock loss");
  a_backplane_held_low: assert property (!st_r.ccr2[0] |=> !backplane_clock_out_o) // RULE14
    else $error("backplane clock not held low while disabled");
  a_backplane_port_only: assert property (PORT_NUM > 2 |-> !backplane_clock_out_o) // RULE15
    else $error("backplane clock active in a port without one");
  a_fallback_clock: assert property (st_r.ccr1[2:1] == 2'h1 && st_r.tx_loss // RULE10
                                     |=> tx_output_clock_o == $past(st_r.rck_s2))
    else $error("fallback mode did not use the recovered clock");
  a_recovered_clock: assert property (st_r.ccr1[2:1] == 2'h3 // RULE11
                                      |=> tx_output_clock_o == $past(st_r.rck_s2))
    else $error("recovered clock mode uses another source");
  a_loss_timing: assert property ($rose(st_r.tx_loss) |-> // RULE10
                                  $past(st_r.idle_cnt) ==
                                  8'(framer_sig_pkg::CHANNEL_TIME_CYCLES - 1))
    else $error("transmit clock loss declared at the wrong time");
  a_idle_advance: assert property (idle_code_access_i && !st_r.ccr1[3] // RULE9
                                   |=> idle_addr_advance_o)
    else $error("idle address did not advance");
  a_idle_hold: assert property (st_r.ccr1[3] |=> !idle_addr_advance_o) // RULE9
    else $error("idle address advanced while disabled");
  a_cas_spare_zero: assert property (multiframe_end_i && frame_mode_i == 2'h2 // RULE3
                                     |=> st_r.vis[0][7:4] == 4'h0)
    else $error("spare byte upper nibble not zero");
  a_half_width: assert property (tx_positive_data_out_o && $past(st_r.ccr1[4]) // RULE8
                                 |-> $past(tx_sel_clk))
    else $error("half width pulse outside clock high");
  a_ack_single: assert property (st_r.ack |=> !st_r.ack) // RULE20
    else $error("bus answer held longer than one cycle");

  c_fallback: cover property (st_r.ccr1[2:1] == 2'h1 && $rose(st_r.tx_loss));
  c_sig_change: cover property (st_r.ccr1[5] && sig_change_o);
  c_read_answer: cover property (avs_read_i && !avs_waitrequest_o);
  c_backplane_on: cover property ($rose(backplane_clock_out_o));
endmodule

// *** test/framer_line_model.sv ***
// Far-side model: framer signaling strobes and the two line clocks.
// Assumes one bench process calls its tasks at a time, all on mclk_i.
`timescale 1ns/1ns
module framer_line_model (
  // Clock and control
  input wire logic mclk_i,
  input wire logic tx_run_i,
  // Signaling strobes
  output logic ch_sig_valid_o,
  output logic [4:0] ch_num_o,
  output logic [3:0] ch_abcd_o,
  output logic ccs_bit_valid_o,
  output logic ccs_bit_o,
  output logic multiframe_end_o,
  // Line clocks
  output logic tx_clk_o,
  output logic rx_clk_o
);
  // Transmit pin clock, 320 ns, stands still while tx_run_i is low
  initial begin
    {ch_sig_valid_o, ch_num_o, ch_abcd_o, ccs_bit_valid_o, ccs_bit_o, multiframe_end_o} = '0;
    tx_clk_o = 1'b0;
    #7;
    forever begin
      #160;
      if (tx_run_i) begin
        tx_clk_o = !tx_clk_o;
      end
    end
  end
  // Recovered clock, 800 ns, so its rate is told apart from the others
  initial begin
    rx_clk_o = 1'b0;
    #13;
    forever #400 rx_clk_o = !rx_clk_o;
  end
  task automatic chan(input logic [4:0] n, input logic [3:0] v);
    @(posedge mclk_i);
    ch_sig_valid_o <= 1'b1;
    ch_num_o <= n;
    ch_abcd_o <= v;
    @(posedge mclk_i);
    ch_sig_valid_o <= 1'b0;
    // Stale data would hide a capture on the wrong cycle
    ch_abcd_o <= ~v;
  endtask
  task automatic ccs(input logic b);
    @(posedge mclk_i);
    ccs_bit_valid_o <= 1'b1;
    ccs_bit_o <= b;
    @(posedge mclk_i);
    ccs_bit_valid_o <= 1'b0;
    ccs_bit_o <= !b;
  endtask
  task automatic mf_end();
    @(posedge mclk_i);
    multiframe_end_o <= 1'b1;
    @(posedge mclk_i);
    multiframe_end_o <= 1'b0;
  endtask
endmodule

// *** test/framer_signaling_common_ctrl_bench.sv ***
// Self-checking bench of the signaling capture and common control bank.
// Assumes framer_line_model on the far side and the package constants.
`timescale 1ns/1ns
module framer_signaling_common_ctrl_bench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] frame_mode_i = '0;
  logic [3:0] spare_bits_i = '0;
  logic tx_pos_bit_i = 1'b0;
  logic rx_sync_loss_i = 1'b0;
  logic int_req_i = 1'b0;
  logic idle_code_access_i = 1'b0;
  logic bp_tick_i = 1'b0;
  logic tx_run = 1'b1;
  logic ch_sig_valid_i, ccs_bit_valid_i, ccs_bit_i, multiframe_end_i, sig_change_o;
  logic tx_clock_input_i, rx_recovered_clock_i, tx_output_clock_o, tx_positive_data_out_o;
  logic loss_indication_o, irq_o, idle_addr_advance_o, backplane_clock_out_o;
  logic tx_negative_data_out_o;
  logic [4:0] ch_num_i;
  logic [3:0] ch_abcd_i;
  logic [6:0] stat;
  logic [3:0] nib [1:30];
  logic [127:0] ccsv;
  logic [7:0] c [3];
  logic [31:0] q;
  int err_count = 0;
  int samples_checked = 0;
  int sig_cnt = 0;
  int seed = 32'hf6bd;
  int r, h;
  always #20 mclk_i = !mclk_i;
  always @(posedge mclk_i) if (sig_change_o === 1'b1) sig_cnt++;
  framer_line_model fm_u (.mclk_i, .tx_run_i(tx_run), .ch_sig_valid_o(ch_sig_valid_i),
    .ch_num_o(ch_num_i), .ch_abcd_o(ch_abcd_i), .ccs_bit_valid_o(ccs_bit_valid_i),
    .ccs_bit_o(ccs_bit_i), .multiframe_end_o(multiframe_end_i), .tx_clk_o(tx_clock_input_i),
    .rx_clk_o(rx_recovered_clock_i));
  framer_signaling_common_ctrl dut_u (.mclk_i, .rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_byteenable_i(4'hf), .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .frame_mode_i, .ch_sig_valid_i, .ch_num_i, .ch_abcd_i, .spare_bits_i,
    .ccs_bit_valid_i, .ccs_bit_i, .multiframe_end_i, .sig_change_o, .tx_clock_input_i,
    .rx_recovered_clock_i, .tx_pos_bit_i, .tx_neg_bit_i(tx_pos_bit_i), .tx_output_clock_o,
    .tx_positive_data_out_o, .tx_negative_data_out_o, .rx_sync_loss_i, .loss_indication_o,
    .int_req_i, .irq_o, .idle_code_access_i, .idle_addr_advance_o, .bp_tick_i,
    .backplane_clock_out_o, .master_clock_source_sel_o(stat[6]),
    .checksum_recalc_mode_o(stat[5]), .tx_multiframe_sync_source_o(stat[4]),
    .tx_channel_rate_sel_o(stat[3]), .tx_gapped_clock_en_o(stat[2]),
    .rx_channel_rate_sel_o(stat[1]), .rx_gapped_clock_en_o(stat[0]));
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waitrequest and read data are taken at the rising edge, before it updates the slave
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge mclk_i);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'($random(seed)), d};
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic measure(input int sel, input int n);
    logic cur, prev;
    r = 0;
    h = 0;
    prev = 1'b1;
    repeat (n) begin
      @(negedge mclk_i);
      cur = (sel == 0) ? tx_output_clock_o : (sel == 1) ? tx_positive_data_out_o :
        (sel == 2) ? backplane_clock_out_o : tx_negative_data_out_o;
      r += int'(cur && !prev);
      h += int'(cur);
      prev = cur;
    end
  endtask
  function automatic logic [31:0] near(input int a, input int b);
    return 32'(a + 2 >= b && a <= b + 2);
  endfunction
  function automatic logic [7:0] sig_byte(input int m, input int i);
    if (m == 2) return (i == 0) ? {4'h0, spare_bits_i} : {nib[2 * i], nib[2 * i - 1]};
    if (m == 3) return ccsv[127 - 8 * i -: 8];
    return (i < 12) ? {nib[2 * i + 2], nib[2 * i + 1]} : 8'h00;
  endfunction
  initial begin
    #(40000 * 40);
    err_count++;
    stop_test();
  end
  initial begin
    int exp_r [4] = '{80, 80, 53, 32};
    logic [7:0] msk [3] = '{8'hff, 8'h07, 8'hcf};
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      bus(0, 8'h70 + 8'(i), 8'h00);
      check(q, 32'h0000_0000);
    end
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 3; i++) begin
        c[i] = 8'($random(seed)) & msk[i];
        bus(1, 8'h70 + 8'(i), c[i] | ~msk[i] & 8'(k << 4));
        bus(0, 8'h70 + 8'(i), 8'h00);
        check(q, {24'h0, c[i]});
      end
      check(stat, {c[0][7:6], c[2][7], c[2][3:0]});
      int_req_i <= 1'($random(seed));
      rx_sync_loss_i <= 1'($random(seed));
      idle_code_access_i <= 1'b1;
      @(posedge mclk_i);
      idle_code_access_i <= 1'b0;
      @(negedge mclk_i);
      check(idle_addr_advance_o, 32'(!c[0][3]));
      measure(3, 3);
      check(int'(idle_addr_advance_o), 0);
      check(irq_o, int_req_i & !c[2][6]);
      check(loss_indication_o, rx_sync_loss_i & !c[0][0]);
    end
    bus(0, 8'h50, 8'h00);
    check(q, 32'h0000_0000);
    // Random control values above may have left integration on
    bus(1, 8'h70, 8'h00);
    for (int m = 0; m < 4; m++) begin
      frame_mode_i <= 2'(m);
      spare_bits_i <= 4'($random(seed));
      for (int cc = 1; cc <= 30 && m < 3; cc++) begin
        nib[cc] = 4'($random(seed));
        if (m == 1) nib[cc] = {nib[cc][1:0], nib[cc][1:0]};
        fm_u.chan(5'(cc), nib[cc]);
      end
      for (int b = 0; b < 128 && m == 3; b++) begin
        ccsv[127 - b] = 1'($random(seed));
        fm_u.ccs(ccsv[127 - b]);
      end
      fm_u.mf_end();
      for (int i = 0; i < 16; i++) begin
        bus(0, 8'h60 + 8'(i), 8'h00);
        check(q, {24'h0, sig_byte(m, i)});
      end
    end
    bus(1, 8'h60, 8'hff);
    bus(0, 8'h60, 8'h00);
    check(q, {24'h0, ccsv[127:120]});
    frame_mode_i <= 2'(0);
    fm_u.chan(5'd1, 4'h3);
    fm_u.mf_end();
    bus(1, 8'h70, 8'h20);
    r = sig_cnt;
    for (int k = 1; k <= 3; k++) begin
      fm_u.chan(5'd1, 4'hc);
      fm_u.mf_end();
      bus(0, 8'h60, 8'h00);
      check(q[3:0], (k < 3) ? 4'h3 : 4'hc);
    end
    check(sig_cnt - r, 1);
    tx_pos_bit_i <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      bus(1, 8'h70, {3'b000, s[0], 1'b0, 2'(s), 1'b0});
      measure(0, 640);
      check(near(r, exp_r[s]), 1);
      measure(1, 640);
      check(s[0] ? (h > 200 && h < 440) : (h >= 630), 1);
      measure(3, 640);
      check(s[0] ? (h > 200 && h < 440) : (h >= 630), 1);
    end
    tx_run <= 1'b0;
    bus(1, 8'h70, 8'h01);
    repeat (150) @(posedge mclk_i);
    check(loss_indication_o, 1);
    measure(0, 640);
    check(near(r, 0), 1);
    bus(1, 8'h70, 8'h03);
    repeat (150) @(posedge mclk_i);
    measure(0, 640);
    check(near(r, 32), 1);
    tx_run <= 1'b1;
    repeat (40) @(posedge mclk_i);
    check(loss_indication_o, 0);
    bp_tick_i <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      bus(1, 8'h71, {5'h00, 2'(s >> 1), s[0]});
      // The output register still carries the old setting for one cycle
      @(posedge mclk_i);
      measure(2, 256);
      check(s[0] ? near(r, 128 >> (s >> 1)) : 32'(h == 0), 1);
    end
    stop_test();
  end
endmodule
